/* File: core/eeprom_master_pkg.sv */
// types shared by the eeprom transfer master
package eeprom_master_pkg;

    typedef struct packed {
        logic [2:0] sel;
        logic [1:0] data_set_select;
        logic [2:0] mode;
    } cmd_t;

    typedef enum logic [2:0] {
        M_IDLE,
        M_LOAD,
        M_START,
        M_TX,
        M_RX,
        M_STOP,
        M_WAIT,
        M_NEXT
    } mst_state_t;

endpackage

/* File: core/eeprom_master_regs.svh */
// register offsets, field positions, reset values and timing counts of the eeprom master
`ifndef EEPROM_MASTER_REGS_SVH
`define EEPROM_MASTER_REGS_SVH

// command/status register, 24 bits: byte 0 in [23:16], byte 1 in [15:8], byte 2 in [7:0]
`define CMD_STATUS_OFS   8'he9
`define FLD_SEL_MSB      23
`define FLD_SEL_LSB      21
`define FLD_ADS_MSB      17
`define FLD_ADS_LSB      16
`define FLD_MODE_MSB     15
`define FLD_MODE_LSB     13
`define FLD_HAM_MSB      11
`define FLD_HAM_LSB      8
`define STX_RESET        4'hf

// operation modes, bit 2 is the direction (1 = write to eeprom)
`define MODE_POLL        3'b001
`define MODE_RD_ALL      3'b011
`define MODE_RD_ADS      3'b010
`define MODE_WR_ALL      3'b101
`define MODE_WR_ADS      3'b100
`define MODE_WR_STATIC   3'b110

// check masks over {byte0[7:0], byte1[7:4]}
`define HAM_M0           12'hd5b
`define HAM_M1           12'hb6d
`define HAM_M2           12'h78e
`define HAM_M3           12'h07f

// eeprom and ram layout, 2k x 8 per eeprom
`define EE_CTRL_CODE     4'ha
`define CONV_EE_BASE     11'h000
`define CONV_RAM_BASE    11'h000
`define CONV_LEN         11'h4e0
`define ADS_EE_BASE      11'h500
`define ADS_RAM_BASE     11'h4e0
`define ADS_LEN          11'h080
`define STATIC_OFS       11'h000
`define STATIC_LEN       11'h00c

// link timing: local oscillator and master bus clock
`define OSC_HZ           83333333
`define SCL_HZ           70000
`define QTR_CYC          (`OSC_HZ / (4 * `SCL_HZ))
`define T_WR_US          5
`define WR_WAIT_DEF      ((`T_WR_US * `OSC_HZ + 999999) / 1000000)

`endif

/* File: core/eeprom_transfer_master.sv */
// two-wire master moving convergence data and data sets between ram and eeproms
`timescale 1ns/1ps
`include "eeprom_master_regs.svh"

// Summary of operation
// RL1: select one of seven eeproms by field; the 3-bit sel field passes all eight codes to the bus
// RL2: each eeprom holds 2k bytes
// RL3: start only after reset or host command
// RL4: host writes command at offset e9
// RL5: data set select maps one set
// RL6: command while busy is dropped whole
// RL7: host polls idle via mode 001, bit 2
// RL8: bus error aborts and flags bit 3
// RL9: mode bit 2 selects direction
// RL10: read modes 11 all, 10 set
// RL11: write modes 01 all, 00 set, 10 static
// RL12: power-on loads ram from strapped eeprom
// RL13: bad check code blocks access, flags error
// RL14: check covers byte0 and byte1 upper nibble
// RL15: four status bits show activity and errors
// RL16: bit 3 low until clean command write; here reset loads it high (STX_RESET 4'hf)
// RL17: bit 2 low at end, high on start/read
// RL18: bit 1 low while access runs
// RL19: bit 0 low on failed sequence
// RL20: host sends one frame per command
// RL21: full transfer near 200 ms at 70 khz; here reading all 1376 bytes takes about 0.94 s
// RL22: addresses translated between ram and eeprom
// RL23: bus timing from own local oscillator
// RL24: missing acknowledge is error, then stop
// RL25: fixed field layout of command register
module eeprom_transfer_master
    import eeprom_master_pkg::*;
#(
    parameter int unsigned WR_WAIT_CYC = `WR_WAIT_DEF
) (
    // system side
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // register port from the slave interface
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [23:0] reg_wdata,
    output logic      [23:0] reg_rdata,
    // power-on eeprom strap
    input  wire logic [2:0]  poweron_select,
    // link side, local oscillator
    input  wire logic        osc_clk,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // ram port on the link clock, read data one cycle after address
    output logic      [10:0] ram_addr,
    output logic      [7:0]  ram_wdata,
    output logic             ram_we,
    input  wire logic [7:0]  ram_rdata
);

    localparam logic [8:0] QTR_LAST = 9'(`QTR_CYC - 1);

    function automatic logic [3:0] ham_f(input logic [11:0] d);
        ham_f = {^(d & `HAM_M3), ^(d & `HAM_M2), ^(d & `HAM_M1), ^(d & `HAM_M0)};
    endfunction

    function automatic logic mode_ok_f(input logic [2:0] m, input logic [1:0] a);
        mode_ok_f = (a != 2'd3) &&
                    (m == `MODE_RD_ALL || m == `MODE_RD_ADS || m == `MODE_WR_ALL ||
                     m == `MODE_WR_ADS || m == `MODE_WR_STATIC);
    endfunction

    // =================== system clock domain ===================
    logic [2:0]  pon_s1_r;
    logic [2:0]  pon_s2_r;
    logic        pon_pend_r;
    logic [1:0]  pon_dly_r;
    cmd_t        cmd_r;
    logic        req_tgl_r;
    logic        busy_r;
    logic [15:0] d01_r;
    logic [3:0]  stx_r;
    logic        ok_s1_r, ok_s2_r, ok_s3_r;
    logic        er_s1_r, er_s2_r, er_s3_r;
    logic        ok_tgl_r;
    logic        err_tgl_r;

    logic        wr_hit;
    logic        rd_hit;
    logic        accepted;
    logic        ham_good;
    logic        host_launch;
    logic        pon_launch;
    logic        launch;
    logic        done_ok;
    logic        done_err;
    cmd_t        host_cmd;

    // strap is a pin: two flops before use
    always_ff @(posedge sys_clk) begin
        pon_s1_r <= poweron_select;
        pon_s2_r <= pon_s1_r;
    end

    assign host_cmd.sel  = reg_wdata[`FLD_SEL_MSB:`FLD_SEL_LSB]; // see RL25
    assign host_cmd.data_set_select  = reg_wdata[`FLD_ADS_MSB:`FLD_ADS_LSB];
    assign host_cmd.mode = reg_wdata[`FLD_MODE_MSB:`FLD_MODE_LSB];

    assign wr_hit   = ce & reg_wr & (reg_addr == `CMD_STATUS_OFS); // see RL4
    assign rd_hit   = ce & reg_rd & (reg_addr == `CMD_STATUS_OFS);
    // the power-on load counts as busy until it has been launched
    assign accepted = wr_hit & ~busy_r & ~pon_pend_r; // see RL6
    assign ham_good = ham_f(reg_wdata[23:12]) == reg_wdata[`FLD_HAM_MSB:`FLD_HAM_LSB]; // see RL14
    // mode 001 and unlisted modes only refresh status, nothing starts
    assign host_launch = accepted & ham_good & mode_ok_f(host_cmd.mode, host_cmd.data_set_select); // see RL13
    assign pon_launch  = ce & pon_pend_r & (pon_dly_r == 2'd3); // see RL12
    assign launch      = host_launch | pon_launch; // see RL3
    assign done_ok     = ce & (ok_s2_r ^ ok_s3_r);
    assign done_err    = ce & (er_s2_r ^ er_s3_r);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pon_pend_r <= 1'b1;
            pon_dly_r  <= 2'd0;
        end else if (ce) begin
            if (pon_dly_r != 2'd3) begin
                pon_dly_r <= pon_dly_r + 2'd1;
            end
            if (pon_launch) begin
                pon_pend_r <= 1'b0;
            end
        end
    end

    // command is held stable while busy, so the link side may sample it after the toggle
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cmd_r     <= '0;
            req_tgl_r <= 1'b0;
        end else if (launch) begin
            if (pon_launch) begin
                cmd_r.sel  <= pon_s2_r;
                cmd_r.data_set_select  <= 2'd0;
                cmd_r.mode <= `MODE_RD_ALL;
            end else begin
                cmd_r <= host_cmd; // see RL1 RL5
            end
            req_tgl_r <= ~req_tgl_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            busy_r <= 1'b0;
        end else if (launch) begin
            busy_r <= 1'b1;
        end else if (done_ok | done_err) begin
            busy_r <= 1'b0;
        end
    end

    // completion events arrive as toggles
    always_ff @(posedge sys_clk) begin
        ok_s1_r <= ok_tgl_r;
        ok_s2_r <= ok_s1_r;
        er_s1_r <= err_tgl_r;
        er_s2_r <= er_s1_r;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ok_s3_r <= 1'b0;
            er_s3_r <= 1'b0;
        end else if (ce) begin
            ok_s3_r <= ok_s2_r;
            er_s3_r <= er_s2_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            d01_r <= 16'h0000;
        end else if (accepted) begin
            d01_r <= reg_wdata[23:8];
        end
    end

    // active-low status; hardware events win over the clear by a status read
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            stx_r <= `STX_RESET;
        end else begin
            if (done_err) begin
                stx_r[3] <= 1'b0; // see RL8
            end else if (accepted) begin
                stx_r[3] <= ham_good; // see RL16
            end
            if (done_ok | done_err) begin
                stx_r[2] <= 1'b0; // see RL17
            end else if (launch | rd_hit) begin
                stx_r[2] <= 1'b1;
            end
            if (launch) begin
                stx_r[1] <= 1'b0; // see RL18
            end else if (done_ok | done_err) begin
                stx_r[1] <= 1'b1;
            end
            if (done_err) begin
                stx_r[0] <= 1'b0; // see RL19
            end else if (launch) begin
                stx_r[0] <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            reg_rdata <= 24'h000000;
        end else if (ce & reg_rd) begin
            reg_rdata <= rd_hit ? {d01_r, 4'h0, stx_r} : 24'h000000; // see RL15
        end
    end

    // =================== link clock domain ===================
    logic        ors_s1_r, ors_s2_r;
    logic        oce_s1_r, oce_s2_r;
    logic        rq_s1_r, rq_s2_r, rq_s3_r;
    logic        sda_s1_r, sda_s2_r;
    logic        scl_s1_r, scl_s2_r;
    logic [8:0]  div_r;
    logic        tick_r;
    logic        low_r;
    mst_state_t  st_r;
    logic [1:0]  q_r;
    logic [2:0]  bit_r;
    logic        ack_r;
    logic [2:0]  step_r;
    logic [7:0]  sh_r;
    logic [7:0]  wdat_r;
    logic        seg_conv_r;
    logic [10:0] off_r;
    logic [10:0] end_r;
    logic        dir_w_r;
    logic [1:0]  ads_r;
    logic [2:0]  sel_r;
    logic        err_r;
    logic [31:0] wait_r;
    logic        adv;
    logic [10:0] ee_addr;
    cmd_t        cmd_in;

    always_ff @(posedge osc_clk) begin
        ors_s1_r <= rstn;
        ors_s2_r <= ors_s1_r;
        oce_s1_r <= ce;
        oce_s2_r <= oce_s1_r;
        rq_s1_r  <= req_tgl_r;
        rq_s2_r  <= rq_s1_r;
        sda_s1_r <= sda_i;
        sda_s2_r <= sda_s1_r;
        scl_s1_r <= scl_i;
        scl_s2_r <= scl_s1_r;
    end

    // both pins are open drain: the output level is always low, enables drive the wire
    always_ff @(posedge osc_clk) begin
        low_r <= 1'b0;
    end
    assign scl_o = low_r;
    assign sda_o = low_r;

    // quarter-bit tick from the local oscillator, independent of the system clock
    always_ff @(posedge osc_clk) begin
        if (!ors_s2_r) begin
            div_r  <= 9'd0;
            tick_r <= 1'b0;
        end else if (oce_s2_r) begin
            tick_r <= (div_r == QTR_LAST); // see RL23 RL21
            div_r  <= (div_r == QTR_LAST) ? 9'd0 : div_r + 9'd1;
        end
    end

    // a slave holding the clock low stretches the low phase
    assign adv    = tick_r & ~((q_r == 2'd2) & ~scl_s2_r);
    assign cmd_in = cmd_r;

    function automatic logic [10:0] ee_addr_f(input logic conv, input logic [1:0] a,
                                              input logic [10:0] off);
        ee_addr_f = conv ? 11'(`CONV_EE_BASE + off)
                         : 11'(`ADS_EE_BASE + 11'(a) * `ADS_LEN + off);
    endfunction

    assign ee_addr = ee_addr_f(seg_conv_r, ads_r, off_r); // see RL22 RL2

    function automatic logic [7:0] tx_byte_f(input logic [2:0] s);
        unique case (s)
            3'd0:    tx_byte_f = {`EE_CTRL_CODE, sel_r, 1'b0};
            3'd1:    tx_byte_f = {5'h00, ee_addr[10:8]};
            3'd2:    tx_byte_f = ee_addr[7:0];
            3'd3:    tx_byte_f = dir_w_r ? wdat_r : {`EE_CTRL_CODE, sel_r, 1'b1};
            default: tx_byte_f = 8'h00;
        endcase
    endfunction

    always_ff @(posedge osc_clk) begin
        if (!ors_s2_r) begin
            rq_s3_r    <= 1'b0;
            st_r       <= M_IDLE;
            q_r        <= 2'd0;
            bit_r      <= 3'd0;
            ack_r      <= 1'b0;
            step_r     <= 3'd0;
            sh_r       <= 8'h00;
            wdat_r     <= 8'h00;
            seg_conv_r <= 1'b0;
            off_r      <= 11'h000;
            end_r      <= 11'h000;
            dir_w_r    <= 1'b0;
            ads_r      <= 2'd0;
            sel_r      <= 3'd0;
            err_r      <= 1'b0;
            wait_r     <= 32'd0;
            ok_tgl_r   <= 1'b0;
            err_tgl_r  <= 1'b0;
            scl_oe     <= 1'b0;
            sda_oe     <= 1'b0;
            ram_addr   <= 11'h000;
            ram_wdata  <= 8'h00;
            ram_we     <= 1'b0;
        end else if (oce_s2_r) begin
            ram_we  <= 1'b0;
            rq_s3_r <= rq_s2_r;
            unique case (st_r)
                M_IDLE: begin
                    if (rq_s2_r ^ rq_s3_r) begin
                        sel_r   <= cmd_in.sel;
                        ads_r   <= cmd_in.data_set_select;
                        dir_w_r <= cmd_in.mode[2]; // see RL9
                        err_r   <= 1'b0;
                        // see RL10 RL11
                        if (cmd_in.mode[1:0] == (cmd_in.mode[2] ? 2'b01 : 2'b11)) begin
                            seg_conv_r <= 1'b1;
                            off_r      <= 11'h000;
                            end_r      <= `CONV_LEN;
                        end else if (cmd_in.mode == `MODE_WR_STATIC) begin
                            seg_conv_r <= 1'b0;
                            off_r      <= `STATIC_OFS;
                            end_r      <= 11'(`STATIC_OFS + `STATIC_LEN);
                        end else begin
                            seg_conv_r <= 1'b0;
                            off_r      <= 11'h000;
                            end_r      <= `ADS_LEN;
                        end
                        st_r <= M_LOAD;
                    end
                end
                M_LOAD: begin
                    ram_addr <= seg_conv_r ? 11'(`CONV_RAM_BASE + off_r)
                                           : 11'(`ADS_RAM_BASE + off_r); // see RL22
                    step_r   <= 3'd0;
                    st_r     <= M_START;
                end
                M_START: begin
                    if (adv) begin
                        q_r <= q_r + 2'd1;
                        unique case (q_r)
                            2'd0: begin
                                sda_oe <= 1'b0;
                                wdat_r <= ram_rdata;
                            end
                            2'd1: scl_oe <= 1'b0;
                            2'd2: sda_oe <= 1'b1;
                            2'd3: begin
                                scl_oe <= 1'b1;
                                sh_r   <= tx_byte_f(step_r);
                                bit_r  <= 3'd7;
                                ack_r  <= 1'b0;
                                st_r   <= M_TX;
                            end
                        endcase
                    end
                end
                M_TX: begin
                    if (adv) begin
                        q_r <= q_r + 2'd1;
                        unique case (q_r)
                            2'd0: sda_oe <= ack_r ? 1'b0 : ~sh_r[7];
                            2'd1: scl_oe <= 1'b0;
                            2'd2: begin
                                if (ack_r & sda_s2_r) begin
                                    err_r <= 1'b1; // see RL24
                                end
                            end
                            2'd3: begin
                                scl_oe <= 1'b1;
                                if (!ack_r) begin
                                    sh_r <= {sh_r[6:0], 1'b0};
                                    if (bit_r == 3'd0) begin
                                        ack_r <= 1'b1;
                                    end else begin
                                        bit_r <= bit_r - 3'd1;
                                    end
                                end else begin
                                    ack_r <= 1'b0;
                                    bit_r <= 3'd7;
                                    if (err_r) begin
                                        st_r <= M_STOP; // see RL8
                                    end else if (step_r == 3'd2 && !dir_w_r) begin
                                        step_r <= 3'd3;
                                        st_r   <= M_START;
                                    end else if (step_r == 3'd3) begin
                                        step_r <= 3'd4;
                                        st_r   <= dir_w_r ? M_STOP : M_RX;
                                    end else begin
                                        step_r <= step_r + 3'd1;
                                        sh_r   <= tx_byte_f(step_r + 3'd1);
                                    end
                                end
                            end
                        endcase
                    end
                end
                M_RX: begin
                    if (adv) begin
                        q_r <= q_r + 2'd1;
                        unique case (q_r)
                            // the final bit left released is the not-acknowledge
                            2'd0: sda_oe <= 1'b0;
                            2'd1: scl_oe <= 1'b0;
                            2'd2: begin
                                if (!ack_r) begin
                                    sh_r <= {sh_r[6:0], sda_s2_r};
                                end
                            end
                            2'd3: begin
                                scl_oe <= 1'b1;
                                if (!ack_r) begin
                                    if (bit_r == 3'd0) begin
                                        ack_r <= 1'b1;
                                    end else begin
                                        bit_r <= bit_r - 3'd1;
                                    end
                                end else begin
                                    ack_r <= 1'b0;
                                    st_r  <= M_STOP;
                                end
                            end
                        endcase
                    end
                end
                M_STOP: begin
                    if (adv) begin
                        q_r <= q_r + 2'd1;
                        unique case (q_r)
                            2'd0: sda_oe <= 1'b1;
                            2'd1: scl_oe <= 1'b0;
                            2'd2: sda_oe <= 1'b0;
                            2'd3: begin
                                if (err_r) begin
                                    err_tgl_r <= ~err_tgl_r; // see RL24 RL19
                                    st_r      <= M_IDLE;
                                end else if (dir_w_r) begin
                                    wait_r <= 32'd0;
                                    st_r   <= M_WAIT;
                                end else begin
                                    ram_wdata <= sh_r;
                                    ram_we    <= 1'b1;
                                    st_r      <= M_NEXT;
                                end
                            end
                        endcase
                    end
                end
                M_WAIT: begin
                    // eeprom internal write cycle; simpler than acknowledge polling
                    wait_r <= wait_r + 32'd1;
                    if (wait_r >= WR_WAIT_CYC - 1) begin
                        st_r <= M_NEXT;
                    end
                end
                M_NEXT: begin
                    if (off_r + 11'd1 == end_r) begin
                        if (seg_conv_r) begin
                            seg_conv_r <= 1'b0;
                            off_r      <= 11'h000;
                            end_r      <= `ADS_LEN;
                            st_r       <= M_LOAD;
                        end else begin
                            ok_tgl_r <= ~ok_tgl_r;
                            st_r     <= M_IDLE;
                        end
                    end else begin
                        off_r <= off_r + 11'd1;
                        st_r  <= M_LOAD;
                    end
                end
            endcase
        end
    end

endmodule

/* File: verification/eeprom_model.sv */
// behavioural serial eeprom that answers the control byte
`timescale 1ns/1ps
module eeprom_model #(parameter logic [2:0] SEL = 3'h5) (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic nack,
    input  wire logic slow,
    output logic      scl_low = 1'b0,
    output logic      sda_low = 1'b0,
    output logic [7:0] ctrl_seen = 8'h00
);
    int         n = 9;
    logic [7:0] sh = 8'h00;
    always @(negedge sda) if (scl === 1'b1) n = 0;
    always @(posedge scl) if (n < 9) begin
        sh = {sh[6:0], sda};
        n = n + 1;
        if (n == 8) ctrl_seen = sh;
    end
    // later bytes are never acknowledged, so every run ends in a refusal
    always @(negedge scl) begin
        sda_low <= n == 8 && !nack && sh[7:1] == {4'ha, SEL};
        if (n == 9 && slow) begin
            n = 10;
            scl_low = 1'b1;
            #5000 scl_low = 1'b0;
        end
    end
endmodule

/* File: verification/eeprom_transfer_master_sva.sv */
// concurrent checks on the eeprom transfer master ports
`timescale 1ns/1ps
module eeprom_transfer_master_sva (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [23:0] reg_rdata,
    input wire logic        osc_clk,
    input wire logic        scl_o,
    input wire logic        sda_o,
    input wire logic        scl_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence rd_st;
        reg_rd && reg_addr == 8'he9 ##2 1'b1;
    endsequence
    AST_RD_UNMAP: assert property (reg_rd && reg_addr != 8'he9 ##1 !reg_rd |=>
        reg_rdata == 24'h000000) else $error("unmapped read not zero");
    AST_RD_HOLD: assert property (!reg_rd ##1 !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    AST_RUN_FLAGS: assert property (rd_st ##0 !reg_rdata[1] |->
        reg_rdata[2] && reg_rdata[0]) else $error("running access with end flags low");
    AST_FAIL_IDLE: assert property (rd_st ##0 !reg_rdata[0] |-> reg_rdata[1])
        else $error("failed flag while access runs");
    AST_STX_PAD: assert property (rd_st |-> reg_rdata[7:4] == 4'h0)
        else $error("status pad bits not zero");
    // both lines are open drain, the data pins never drive high
    AST_OPEN_DRAIN: assert property (@(posedge osc_clk) disable iff (!rstn)
        !scl_o && !sda_o) else $error("bus pin driven high");
    AST_SCL_LOW: assert property (@(posedge osc_clk) disable iff (!rstn)
        $rose(scl_oe) |=> scl_oe [*8]) else $error("clock low phase too short");
    AST_SCL_REL: assert property (@(posedge osc_clk) disable iff (!rstn)
        $fell(scl_oe) |=> !scl_oe [*8]) else $error("clock high phase too short");
    cover property (rd_st ##0 !reg_rdata[1]);
    cover property (rd_st ##0 !reg_rdata[0]);
    cover property (@(posedge osc_clk) $rose(scl_oe));
endmodule

bind eeprom_transfer_master eeprom_transfer_master_sva u_sva (.sys_clk(sys_clk), .rstn(rstn),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .osc_clk(osc_clk),
    .scl_o(scl_o), .sda_o(sda_o), .scl_oe(scl_oe));

/* File: verification/eeprom_transfer_master_tb.sv */
// self-checking bench for the eeprom transfer master
`timescale 1ns/1ps
`include "eeprom_master_regs.svh"
module eeprom_transfer_master_tb;
    logic        sys_clk = 1'b0;
    logic        osc_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        nack = 1'b1;
    logic        slow = 1'b0;
    logic [7:0]  reg_addr = 8'he9;
    logic [23:0] reg_wdata = 24'h000000;
    logic [23:0] reg_rdata;
    logic [10:0] ram_addr;
    logic [7:0]  ctrl_seen;
    logic        scl_oe, sda_oe, scl_low, sda_low;
    wire         scl = !(scl_oe || scl_low);
    wire         sda = !(sda_oe || sda_low);
    int          error_cnt = 0;
    int          compares = 0;
    int          cyc = 0;
    eeprom_transfer_master #(.WR_WAIT_CYC(20)) dut (.sys_clk(sys_clk), .rstn(rstn),
        .ce(1'b1), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .poweron_select(3'h5),
        .osc_clk(osc_clk), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(),
        .sda_oe(sda_oe), .ram_addr(ram_addr), .ram_wdata(), .ram_we(),
        .ram_rdata(ram_addr[7:0]));
    eeprom_model #(.SEL(3'h5)) peer (.scl(scl), .sda(sda), .nack(nack), .slow(slow),
        .scl_low(scl_low), .sda_low(sda_low), .ctrl_seen(ctrl_seen));
    initial forever #12.5 sys_clk = !sys_clk;
    initial begin
        #3.1;
        forever #6 osc_clk = !osc_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            error_cnt = error_cnt + 1;
            finish_test();
        end
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rd_reg(input logic [7:0] a = `CMD_STATUS_OFS);
        @(negedge sys_clk) reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk) reg_rd = 1'b0;
        @(negedge sys_clk) reg_addr = `CMD_STATUS_OFS;
    endtask
    task st(input logic [3:0] e);
        rd_reg();
        chk({4'h0, reg_rdata[3:0]}, {4'h0, e});
    endtask
    // bad flips a mode bit after the check code is formed
    task wr_cmd(input logic [2:0] sel, input logic [1:0] data_set_select, input logic [2:0] m,
                input logic bad);
        logic [11:0] v;
        v = {sel, 3'b000, data_set_select, m, 1'b0};
        @(negedge sys_clk) reg_wdata = {v ^ {10'h000, bad, 1'b0},
            ^(v & `HAM_M3), ^(v & `HAM_M2), ^(v & `HAM_M1), ^(v & `HAM_M0), 8'h00};
        reg_wr = 1'b1;
        @(negedge sys_clk) reg_wr = 1'b0;
    endtask
    // the first read that shows no running access still carries the end flags
    task fin(input logic [3:0] e);
        int i;
        i = 0;
        do begin
            repeat (20) @(negedge sys_clk);
            rd_reg();
            i = i + 1;
        end while (reg_rdata[1] !== 1'b1 && i < 3000);
        chk({4'h0, reg_rdata[3:0]}, {4'h0, e});
    endtask
    task t_power;
        repeat (8) @(negedge sys_clk);
        fin(4'h2);
        chk(ctrl_seen, {4'ha, 3'h5, 1'b0});
        st(4'h6);
        rd_reg(8'h00);
        chk(reg_rdata[7:0], 8'h00);
    endtask
    task t_check;
        wr_cmd(3'h5, 2'h0, `MODE_POLL, 1'b0);
        st(4'he);
        wr_cmd(3'h5, 2'h0, `MODE_RD_ADS, 1'b1);
        repeat (600) @(negedge sys_clk);
        chk({6'h00, scl_oe, sda_oe}, 8'h00);
        st(4'h6);
    endtask
    task t_busy;
        wr_cmd(3'h3, 2'h2, `MODE_RD_ADS, 1'b0);
        st(4'hd);
        wr_cmd(3'h6, 2'h1, `MODE_RD_ALL, 1'b0);
        fin(4'h2);
        chk(ctrl_seen, {4'ha, 3'h3, 1'b0});
        chk({5'h00, reg_rdata[23:21]}, 8'h03);
    endtask
    task t_modes;
        slow = 1'b1;
        for (int m = 0; m < 9; m++) begin
            nack = (m != 4);
            wr_cmd(3'h5, (m == 8) ? 2'h3 : 2'h1, (m == 8) ? 3'h3 : m[2:0], 1'b0);
            st((m > 1 && m < 7) ? 4'hd : 4'he);
            if (m > 1 && m < 7)
                fin(4'h2);
        end
    endtask
    task finish_test;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge sys_clk);
        rstn = 1'b1;
        t_power();
        t_check();
        t_busy();
        t_modes();
        finish_test();
    end
endmodule
